// ### hw/kef_defs.svh
// Constants of the key event queue readout block
// Assumes inclusion by bare name from the design file of the top module
`ifndef KEF_DEFS_SVH
`define KEF_DEFS_SVH
// Register offsets
`define KEF_A_QUEUE   3'h0
`define KEF_A_CFG     3'h1
`define KEF_A_DEB     3'h2
`define KEF_A_RATE    3'h3
`define KEF_A_PORT    3'h4
`define KEF_A_RPT     3'h5
`define KEF_A_SLEEP   3'h6
// Power-up values
`define KEF_RST_QUEUE 8'h3f
`define KEF_RST_CFG   8'h0a
`define KEF_RST_DEB   8'hff
`define KEF_RST_RATE  8'h00
`define KEF_RST_PORT  8'hfe
`define KEF_RST_RPT   8'h00
`define KEF_RST_SLEEP 8'h07
// Queue read codes
`define KEF_CODE_EMPTY 8'h3f
`define KEF_CODE_OVF   8'h7f
`define KEF_CODE_RPT   6'h3e
`define KEF_KEY_62     6'h3e
// Configuration bit positions
`define KEF_CFG_RUN   7
`define KEF_CFG_DEASS 5
`define KEF_CFG_REL   3
`define KEF_CFG_WAKE  1
// Queue depth
`define KEF_DEPTH     32
`endif

// ### hw/kef_pkg.sv
// Types of the key event queue readout block
// Assumes kef_defs.svh is on the include path
package kef_pkg;
  // One queued key event
  typedef struct packed {
    logic       rpt;
    logic       rel;
    logic [5:0] key;
  } kef_evt_s;
  // Register state of the top module
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] deb;
    logic [7:0] rate;
    logic [7:0] port;
    logic [7:0] rpt;
    logic [7:0] slp;
    logic       ovf;
    logic       alert_n;
    logic [7:0] rdata;
    logic       rvalid;
  } kef_regs_s;
endpackage : kef_pkg

// ### hw/kef_top.sv
// Key event queue, register file and alert output of the key controller
// Assumes the serial bus decoder hands over byte reads and writes,
// and the scanner hands over debounced events with column and row.
// What this block does
// - After reset all registers hold power-up values, device sleeping.
// - Queue read carries the event's key number in bits 5..0, autorepeat excepted.
// - Key number equals column times eight plus row.
// - For keys below 62, bit 7 says more events remain.
// - For keys below 62, bit 6 marks release versus press.
// - Keys 62 and 63 read with bit 7 set; host reads again.
// - Queue register is read-only, powers up and reads empty as 0x3F.
// - After overflow a queue read returns 0x7F.
// - Autorepeat reads as 111110, bit 7 clear, bit 6 more-follow.
// - Queue read clears the alert depending on configuration bit 5.
// - Configuration bit 7 is run/sleep; host and autowake update it.
// - Configuration holds feature enables and powers up 0x0A.
// - Debounce register powers up 0xFF, port control 0xFE.
// - Rate and repeat registers power up 0x00, sleep time 0x07.
// - Mode 0 clears alert on empty queue; mode 1 after host read.
`include "kef_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Event queue with valid/ready on both sides
module kef_fifo #(
  parameter int W = 8,
  parameter int D = `KEF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          rdy;
  } kef_fst_s;
  kef_fst_s       s_r, s_nxt;
  logic [W-1:0]   mem [D];
  logic           push, pop;

  // Handshakes
  assign push      = in_valid && s_r.rdy;
  assign pop       = out_ready && (s_r.cnt != '0);
  assign in_ready  = s_r.rdy;
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rp];
  assign count     = s_r.cnt;

  // Pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (push) s_nxt.wp = s_r.wp + 1'b1;
    if (pop) s_nxt.rp = s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_nxt.rdy = (s_nxt.cnt != (AW+1)'(D));
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[s_r.wp] <= in_data;
  end
endmodule : kef_fifo

module kef_top
  import kef_pkg::*;
#(
  parameter int DEPTH = `KEF_DEPTH
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Register access from the serial bus decoder
  input  wire logic [2:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic [7:0]      REG_RDATA,
  output logic            REG_RVALID,
  // Debounced events from the scanner
  input  wire logic       EVT_VALID,
  input  wire logic [2:0] EVT_COL,
  input  wire logic [2:0] EVT_ROW,
  input  wire logic       EVT_REL,
  input  wire logic       EVT_RPT,
  output logic            EVT_READY,
  // Alert and configuration outputs
  output logic            ALERT_N,
  output logic [7:0]      CFG_OUT,
  output logic [7:0]      DEB_OUT,
  output logic [7:0]      RATE_OUT,
  output logic [7:0]      PORT_OUT,
  output logic [7:0]      RPT_OUT,
  output logic [7:0]      SLEEP_OUT
);
  localparam int CW = $clog2(DEPTH) + 1;
  kef_regs_s      r_r, r_nxt;
  kef_evt_s       in_evt, head;
  logic           in_valid, in_ready, out_valid, pop, push, qrd;
  logic [CW-1:0]  cnt;
  logic [7:0]     code;

  // Event intake; non-repeat release events dropped when release detection is off
  assign in_evt.key = {EVT_COL, EVT_ROW};
  assign in_evt.rel = EVT_REL;
  assign in_evt.rpt = EVT_RPT;
  assign in_valid   = EVT_VALID && !(EVT_REL && !EVT_RPT && !r_r.cfg[`KEF_CFG_REL]);
  assign push       = in_valid && in_ready;
  assign qrd        = REG_RD && (REG_ADDR == `KEF_A_QUEUE);
  assign pop        = qrd && !r_r.ovf && out_valid;

  kef_fifo #(.W($bits(kef_evt_s)), .D(DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_evt),
    .out_valid (out_valid),
    .out_ready (pop),
    .out_data  (head),
    .count     (cnt)
  );

  // Queue read code for the head event
  always_comb begin
    if (r_r.ovf) begin
      code = `KEF_CODE_OVF;
    end else if (!out_valid) begin
      code = `KEF_CODE_EMPTY;
    end else if (head.rpt) begin
      code = {1'b0, (cnt > CW'(1)), `KEF_CODE_RPT};
    end else if (head.key >= `KEF_KEY_62) begin
      code = {1'b1, head.rel, head.key};
    end else begin
      code = {(cnt > CW'(1)), head.rel, head.key};
    end
  end

  // Register file, overflow, alert and read data
  always_comb begin
    r_nxt = r_r;
    r_nxt.rvalid = REG_RD;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `KEF_A_QUEUE: r_nxt.rdata = code;
        `KEF_A_CFG:   r_nxt.rdata = r_r.cfg;
        `KEF_A_DEB:   r_nxt.rdata = r_r.deb;
        `KEF_A_RATE:  r_nxt.rdata = r_r.rate;
        `KEF_A_PORT:  r_nxt.rdata = r_r.port;
        `KEF_A_RPT:   r_nxt.rdata = r_r.rpt;
        `KEF_A_SLEEP: r_nxt.rdata = r_r.slp;
        default:      r_nxt.rdata = 8'h00;
      endcase
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        `KEF_A_CFG:   r_nxt.cfg = REG_WDATA;
        `KEF_A_DEB:   r_nxt.deb = REG_WDATA;
        `KEF_A_RATE:  r_nxt.rate = REG_WDATA;
        `KEF_A_PORT:  r_nxt.port = REG_WDATA;
        `KEF_A_RPT:   r_nxt.rpt = REG_WDATA;
        `KEF_A_SLEEP: r_nxt.slp = REG_WDATA;
        default:      r_nxt.cfg = r_r.cfg; // Queue is read-only
      endcase
    end
    // Autowake on a key press; wins over a host write
    if (push && !EVT_REL && r_r.cfg[`KEF_CFG_WAKE]) r_nxt.cfg[`KEF_CFG_RUN] = 1'b1;
    // Overflow reported once, a new loss wins over the clear
    if (qrd && r_r.ovf) r_nxt.ovf = 1'b0;
    if (in_valid && !in_ready) r_nxt.ovf = 1'b1;
    // Alert clear by mode, new event wins
    if (r_r.cfg[`KEF_CFG_DEASS]) begin
      if (qrd) r_nxt.alert_n = 1'b1;
    end else if (cnt == CW'(0)) begin
      r_nxt.alert_n = 1'b1;
    end
    if (push) r_nxt.alert_n = 1'b0;
  end

  // State register with power-up values, sleep state at reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      r_r <= '{cfg: `KEF_RST_CFG, deb: `KEF_RST_DEB, rate: `KEF_RST_RATE,
               port: `KEF_RST_PORT, rpt: `KEF_RST_RPT,
               slp: `KEF_RST_SLEEP, ovf: 1'b0, alert_n: 1'b1,
               rdata: `KEF_RST_QUEUE, rvalid: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA  = r_r.rdata;
  assign REG_RVALID = r_r.rvalid;
  assign EVT_READY  = in_ready;
  assign ALERT_N    = r_r.alert_n;
  assign CFG_OUT    = r_r.cfg;
  assign DEB_OUT    = r_r.deb;
  assign RATE_OUT   = r_r.rate;
  assign PORT_OUT   = r_r.port;
  assign RPT_OUT    = r_r.rpt;
  assign SLEEP_OUT  = r_r.slp;

  // Checks on the readout behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_reset_sleep: assert property ($past(RST) |-> !CFG_OUT[`KEF_CFG_RUN] && ALERT_N)
    else $error("not sleeping after reset");
  a_cfg_reset: assert property ($past(RST) && !$past(REG_WR) |-> CFG_OUT == `KEF_RST_CFG)
    else $error("configuration power-up value wrong");
  a_deb_port_reset: assert property ($past(RST) |-> DEB_OUT == `KEF_RST_DEB && PORT_OUT == `KEF_RST_PORT)
    else $error("debounce or port power-up value wrong");
  a_misc_reset: assert property ($past(RST) |-> RATE_OUT == `KEF_RST_RATE && RPT_OUT == `KEF_RST_RPT
                                 && SLEEP_OUT == `KEF_RST_SLEEP)
    else $error("rate, repeat or sleep power-up wrong");
  a_empty_code: assert property (qrd && !r_r.ovf && cnt == 0 |=> REG_RVALID && REG_RDATA == `KEF_CODE_EMPTY)
    else $error("empty queue code wrong");
  a_ovf_code: assert property (qrd && r_r.ovf |=> REG_RDATA == `KEF_CODE_OVF)
    else $error("overflow code wrong");
  a_key_number: assert property (push |-> in_evt.key == 6'(EVT_COL * 8 + EVT_ROW))
    else $error("key numbering wrong");
  a_low_key: assert property (pop && !head.rpt && head.key < 62 |=> REG_RDATA[5:0] == $past(head.key) && REG_RDATA[7] == ($past(cnt) > 1) && REG_RDATA[6] == $past(head.rel))
    else $error("ordinary key read wrong");
  a_high_key: assert property (pop && !head.rpt && head.key >= 62 |=> REG_RDATA[7] && REG_RDATA[5:1] == 5'h1f)
    else $error("key 62 or 63 read wrong");
  a_repeat_code: assert property (pop && head.rpt |=> REG_RDATA[7] == 1'b0 && REG_RDATA[5:0] == 6'h3e && REG_RDATA[6] == ($past(cnt) > 1))
    else $error("autorepeat code wrong");
  a_pop_one: assert property (pop |=> cnt == $past(cnt) - 1 + CW'($past(push)))
    else $error("queue read did not remove one event");
  a_alert_read: assert property (qrd && r_r.cfg[`KEF_CFG_DEASS] && !push |=> ALERT_N)
    else $error("alert not cleared after read");
  a_alert_empty: assert property (!r_r.cfg[`KEF_CFG_DEASS] && cnt == 0 && !push |=> ALERT_N)
    else $error("alert not cleared on empty queue");
  a_alert_hold: assert property (!r_r.cfg[`KEF_CFG_DEASS] && !ALERT_N && cnt != 0 |=> !ALERT_N)
    else $error("alert cleared with events queued");
  a_run_write: assert property (REG_WR && REG_ADDR == `KEF_A_CFG && !push
                                |=> CFG_OUT[`KEF_CFG_RUN] == $past(REG_WDATA[`KEF_CFG_RUN]))
    else $error("run bit write lost");
endmodule : kef_top

`default_nettype wire

// ### test/kef_host.sv
// Host model: single byte reads and writes on the register strobe port
// Assumes the bench clock; every request starts just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module kef_host (
  // Clock
  input  wire logic       clk,
  // Register strobe port
  output logic [2:0]      addr,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // Idle levels at time zero
  initial begin
    addr = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // One write strobe; data turned over afterwards so stale bytes never match
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : write
  // One read strobe; data only counts while the answer strobe is up
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask : read
endmodule : kef_host
`default_nettype wire

// ### test/key_event_fifo_readout_tb_top.sv
// Self-checking bench of the key event queue readout block
// Assumes kef_host speaks for the host; the bench acts as the key scanner
`timescale 1ns/1ps
`default_nettype none
module key_event_fifo_readout_tb_top import kef_pkg::*;;
  logic       clk, rst, wr, rd, rvalid, ev_v, ev_rel, ev_rpt, ev_rdy, alert_n;
  logic [2:0] addr, ev_col, ev_row;
  logic [7:0] wdata, rdata, cfg;
  int         n_fail, n_checks;
  int         cyc = 0;
  // Small queue depth keeps overflow reachable
  kef_top #(.DEPTH(4)) uut (
    .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .EVT_VALID(ev_v), .EVT_COL(ev_col), .EVT_ROW(ev_row), .EVT_REL(ev_rel),
    .EVT_RPT(ev_rpt), .EVT_READY(ev_rdy), .ALERT_N(alert_n), .CFG_OUT(cfg),
    .DEB_OUT(), .RATE_OUT(), .PORT_OUT(), .RPT_OUT(), .SLEEP_OUT());
  kef_host host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Offer one scanner event for a single cycle, taken only if ready
  task automatic push(input logic [2:0] c, input logic [2:0] r, input logic rl, input logic rp);
    @(posedge clk);
    ev_v <= 1'b1;
    ev_col <= c;
    ev_row <= r;
    ev_rel <= rl;
    ev_rpt <= rp;
    @(posedge clk);
    ev_v <= 1'b0;
  endtask : push
  task automatic rdq(input logic [7:0] exp, input string nm);
    logic [7:0] d;
    host.read(3'h0, d);
    check(nm, d, exp);
  endtask : rdq
  // Power-up values, unmapped offset and the read-only queue
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] exp [8] = '{8'h3f, 8'h0a, 8'hff, 8'h00, 8'hfe, 8'h00, 8'h07, 8'h00};
    for (int a = 0; a < 8; a++) begin
      host.read(a[2:0], d);
      check("reg", d, exp[a]);
    end
    check("alert", {7'h0, alert_n}, 8'h01);
    host.write(3'h0, 8'h55);
    rdq(8'h3f, "ro_queue");
  endtask : t_reset
  // Key numbering, flag bits, special codes and alert clear on empty
  task automatic t_codes;
    push(3'h0, 3'h0, 1'b0, 1'b1);
    push(3'h1, 3'h0, 1'b1, 1'b0);
    push(3'h7, 3'h7, 1'b0, 1'b0);
    push(3'h7, 3'h6, 1'b1, 1'b0);
    @(negedge clk);
    check("alert", {7'h0, alert_n}, 8'h00);
    check("run", {7'h0, cfg[7]}, 8'h01);
    rdq(8'h7e, "rpt_more");
    check("alert", {7'h0, alert_n}, 8'h00);
    rdq(8'hc8, "key8_rel");
    rdq(8'hbf, "key63");
    rdq(8'hfe, "key62");
    rdq(8'h3f, "empty");
    check("alert", {7'h0, alert_n}, 8'h01);
  endtask : t_codes
  // Read-clear alert mode, full queue, overflow code, last repeat
  task automatic t_ovf;
    logic [7:0] d;
    host.write(3'h1, 8'h28);
    host.read(3'h1, d);
    check("cfg", d, 8'h28);
    for (int i = 0; i < 3; i++) push(3'h0, 3'h2, 1'b0, 1'b0);
    push(3'h0, 3'h0, 1'b0, 1'b1);
    @(posedge clk);
    @(negedge clk);
    check("ready", {7'h0, ev_rdy}, 8'h00);
    push(3'h0, 3'h3, 1'b0, 1'b0);
    rdq(8'h7f, "ovf");
    check("alert", {7'h0, alert_n}, 8'h01);
    for (int i = 0; i < 3; i++) rdq(8'h82, "key2");
    rdq(8'h3e, "rpt_last");
  endtask : t_ovf
  // Release detection and autowake off, plain register write
  task automatic t_misc;
    logic [7:0] d;
    host.write(3'h1, 8'h00);
    push(3'h0, 3'h5, 1'b1, 1'b0);
    @(negedge clk);
    check("rel_off", {7'h0, alert_n}, 8'h01);
    rdq(8'h3f, "rel_drop");
    push(3'h0, 3'h5, 1'b0, 1'b0);
    @(negedge clk);
    check("wake_off", {7'h0, cfg[7]}, 8'h00);
    rdq(8'h05, "last_press");
    host.write(3'h6, 8'h5a);
    host.read(3'h6, d);
    check("sleep_wr", d, 8'h5a);
  endtask : t_misc
  // Main sequence
  initial begin
    rst = 1'b1;
    ev_v = 1'b0;
    ev_col = 3'h0;
    ev_row = 3'h0;
    ev_rel = 1'b0;
    ev_rpt = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_codes();
    t_ovf();
    t_misc();
    final_report();
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
endmodule : key_event_fifo_readout_tb_top
`default_nettype wire
